// ### rtl/qwsl_pkg.sv
// constants, types and helpers shared by the quad wiper serial loader
package qwsl_pkg;

  // channel count and serial word layout: two address bits, then eight data bits, msb first
  localparam int NUM_CH = 4;
  localparam int ADDR_BITS = 2;
  localparam int DATA_BITS = 8;
  localparam int WORD_BITS = ADDR_BITS + DATA_BITS;

  // edge counter on the link side, counting only while selected, wide enough for a ten bit frame
  localparam int CNT_BITS = 5;
  localparam logic [CNT_BITS-1:0] FRAME_LEN = 5'h0A;

  // wiper code registers, indexed by the address code of the word
  localparam logic [ADDR_BITS-1:0] WIPER_CODE_CH1_OFFSET = 2'h0;
  localparam logic [ADDR_BITS-1:0] WIPER_CODE_CH2_OFFSET = 2'h1;
  localparam logic [ADDR_BITS-1:0] WIPER_CODE_CH3_OFFSET = 2'h2;
  localparam logic [ADDR_BITS-1:0] WIPER_CODE_CH4_OFFSET = 2'h3;
  localparam logic [DATA_BITS-1:0] MIDSCALE_CODE = 8'h80;

  // reset values of the pin synchronisers: select, preset and shutdown all idle high
  localparam logic [2:0] PIN_SYNC_RESET = 3'h7;
  localparam logic [CNT_BITS-1:0] CNT_SYNC_RESET = 5'h00;

  // settle time after select rises, long enough for the last edge count to cross over
  localparam int MCLK_PERIOD_NS = 10;
  localparam int SETTLE_NS = 40;
  localparam int SETTLE_CYCLES = (SETTLE_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;
  localparam int SETTLE_W = 4;
  localparam logic [SETTLE_W-1:0] SETTLE_LAST = SETTLE_W'(SETTLE_CYCLES - 1);

  // one serial word as it sits in the input shift register
  typedef struct packed {
    logic [ADDR_BITS-1:0] addr;
    logic [DATA_BITS-1:0] data;
  } qwsl_word_t;

  typedef logic [DATA_BITS-1:0] qwsl_code_t;

  // core sequencer states
  typedef enum logic [2:0] {QW_INIT, QW_IDLE, QW_FRAME, QW_SETTLE, QW_LOAD} qwsl_state_t;

  // state of the serial clock domain
  typedef struct packed {
    qwsl_word_t shift;
    logic [CNT_BITS-1:0] count_gray;
  } qwsl_link_t;

  // state of the system clock domain
  typedef struct packed {
    qwsl_state_t state;
    logic [SETTLE_W-1:0] settle_cnt;
    logic [CNT_BITS-1:0] base_cnt;
    logic [NUM_CH-1:0][DATA_BITS-1:0] wiper;
    logic [NUM_CH-1:0] term_open;
    logic load_pulse;
    logic frame_err;
    logic [ADDR_BITS-1:0] last_addr;
    logic [CNT_BITS-1:0] last_len;
  } qwsl_core_t;

  function automatic logic [CNT_BITS-1:0] bin2gray(input logic [CNT_BITS-1:0] b);
    return b ^ (b >> 1);
  endfunction

  function automatic logic [CNT_BITS-1:0] gray2bin(input logic [CNT_BITS-1:0] g);
    logic [CNT_BITS-1:0] b;
    b[CNT_BITS-1] = g[CNT_BITS-1];
    for (int i = CNT_BITS - 2; i >= 0; i--)
    begin
      b[i] = b[i+1] ^ g[i];
    end
    return b;
  endfunction

endpackage

// ### rtl/qwsl_sync.sv
// two flip-flop synchroniser for levels and gray coded words
`timescale 1ns/1ps
`default_nettype none
module qwsl_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);

  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
  } qwsl_sync_state_t;

  qwsl_sync_state_t sync_reg;
  qwsl_sync_state_t sync_next;

  // first stage feeds only the second stage
  always_comb
  begin
    sync_next.s1 = d;
    sync_next.s2 = sync_reg.s1;
    if (!reset_n)
    begin
      sync_next.s1 = RST_VAL;
      sync_next.s2 = RST_VAL;
    end
  end

  always_ff @(posedge mclk)
  begin
    sync_reg <= sync_next;
  end

  assign q = sync_reg.s2;

endmodule
`default_nettype wire

// ### rtl/qwsl_loader.sv
// serial write port and wiper code registers of the four channel resistor
//
// Operation
// - data input is shifted in on every rising serial clock edge while select is low.
// - select rising edge decodes the address bits of the shifted word.
// - after that edge and the settle time, the data bits of a ten bit word replace the addressed wiper code.
// - address 00 picks channel one, address 01 picks channel two.
// - address 10 picks channel three, address 11 picks channel four.
// - while preset is low every wiper code is forced to 80 hex.
// - shutdown is active low and opens terminal A while low.
// - one shutdown input opens all four channels together, never one alone.
// - serial output only pulls low; an external pull-up gives the high.
`timescale 1ns/1ps
`default_nettype none
module qwsl_loader
  import qwsl_pkg::*;
#(
  parameter int FRAME_BITS = 10
) (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic serial_in,
  input wire logic midscale_preset_n,
  input wire logic terminal_open_n,
  output logic serial_out_od_o,
  output logic serial_out_od_oe,
  output logic [qwsl_pkg::DATA_BITS-1:0] wiper_ch1,
  output logic [qwsl_pkg::DATA_BITS-1:0] wiper_ch2,
  output logic [qwsl_pkg::DATA_BITS-1:0] wiper_ch3,
  output logic [qwsl_pkg::DATA_BITS-1:0] wiper_ch4,
  output logic [qwsl_pkg::NUM_CH-1:0] term_a_open,
  output logic load_done,
  output logic frame_error,
  output logic [qwsl_pkg::ADDR_BITS-1:0] last_addr,
  output logic [qwsl_pkg::CNT_BITS-1:0] last_frame_len
);
  import qwsl_pkg::*;

  // expected frame length at the width of the edge counter
  localparam logic [CNT_BITS-1:0] FRAME_LEN_P = CNT_BITS'(FRAME_BITS);

  // serial clock domain: input shift register and edge counter

  qwsl_link_t link_reg;
  qwsl_link_t link_next;
  logic [CNT_BITS-1:0] link_cnt_bin;

  // shift and count only while selected; the core reads the edge count
  // as a difference, so only its start after reset has to be known
  always_comb
  begin
    link_next = link_reg;
    link_cnt_bin = gray2bin(link_reg.count_gray);
    if (!cs_n)
    begin
      // shift msb first, newest bit enters at the bottom
      link_next.shift = qwsl_word_t'({link_reg.shift[WORD_BITS-2:0], serial_in});
      // gray counter so the core may sample it across the domain
      link_next.count_gray = bin2gray(link_cnt_bin + 5'h01);
    end
  end

  // cleared together with the core so the edge count starts known; the serial
  // clock stands still during reset, so the release never meets an edge
  always_ff @(posedge sclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      link_reg <= '0;
    end
    else
    begin
      link_reg <= link_next;
    end
  end

  // open drain output: the pin is only ever pulled low, and only while
  // selected, so several loaders may share one pulled-up line
  assign serial_out_od_o = 1'b0;
  assign serial_out_od_oe = ~cs_n & ~link_reg.shift[WORD_BITS-1];

  // crossings into the system clock domain

  logic [2:0] pin_sync;
  logic [CNT_BITS-1:0] cnt_gray_sync;
  logic cs_n_s;
  logic preset_n_s;
  logic shutdown_n_s;
  logic [CNT_BITS-1:0] cnt_now;

  // select, preset and shutdown are plain levels
  qwsl_sync #(
    .WIDTH(3),
    .RST_VAL(PIN_SYNC_RESET)
  ) u_pin_sync (
    .mclk(mclk),
    .reset_n(reset_n),
    .d({cs_n, midscale_preset_n, terminal_open_n}),
    .q(pin_sync)
  );

  // the edge count changes one bit at a time, so two stages are enough
  qwsl_sync #(
    .WIDTH(CNT_BITS),
    .RST_VAL(CNT_SYNC_RESET)
  ) u_cnt_sync (
    .mclk(mclk),
    .reset_n(reset_n),
    .d(link_reg.count_gray),
    .q(cnt_gray_sync)
  );

  // unpack the synchronised levels and decode the count
  assign cs_n_s = pin_sync[2];
  assign preset_n_s = pin_sync[1];
  assign shutdown_n_s = pin_sync[0];
  assign cnt_now = gray2bin(cnt_gray_sync);

  // system clock domain: frame tracking and wiper code registers

  qwsl_core_t core_reg;
  qwsl_core_t core_next;
  logic [CNT_BITS-1:0] frame_len;
  qwsl_word_t word_in;

  // the shift register is only read while select is high and shifting is
  // therefore stopped, so the whole word is stable at that time
  assign word_in = link_reg.shift;

  // length of the frame just closed, modulo the counter width
  assign frame_len = cnt_now - core_reg.base_cnt;

  // load strobe for the channels: only in the load cycle and only for a ten bit word
  logic load_now;
  logic frame_ok;
  logic [NUM_CH-1:0] ch_sel;
  logic [NUM_CH-1:0][DATA_BITS-1:0] code_next;
  logic [NUM_CH-1:0] open_next;

  assign load_now = (core_reg.state == QW_LOAD);
  assign frame_ok = (frame_len == FRAME_LEN_P);

  // one copy per channel: address decode, then load, preset or hold
  for (genvar ch = 0; ch < NUM_CH; ch++)
  begin : g_chan
    logic [DATA_BITS-1:0] code_sel;

    // the address code is the channel index: 00 ch1, 01 ch2, 10 ch3, 11 ch4
    assign ch_sel[ch] = load_now & frame_ok & (word_in.addr == ADDR_BITS'(ch));

    // preset is applied last, so it wins over a load in the same cycle
    always_comb
    begin
      code_sel = core_reg.wiper[ch];
      if (ch_sel[ch])
      begin
        code_sel = word_in.data;
      end
      if (!preset_n_s)
      begin
        code_sel = MIDSCALE_CODE;
      end
    end

    // every channel follows the one shutdown level, none has its own
    assign code_next[ch] = code_sel;
    assign open_next[ch] = ~shutdown_n_s;
  end

  always_comb
  begin
    core_next = core_reg;
    core_next.load_pulse = 1'b0;

    // codes and terminal state come from the per channel logic
    core_next.wiper = code_next;
    core_next.term_open = open_next;

    // select rise to new code: two sync stages, one detect cycle in QW_FRAME, four settle cycles, one load cycle
    case (core_reg.state)
      // after reset, wait for the count to settle and take it as the base
      QW_INIT:
      begin
        if (core_reg.settle_cnt == SETTLE_LAST)
        begin
          core_next.base_cnt = cnt_now;
          core_next.settle_cnt = '0;
          core_next.state = QW_IDLE;
        end
        else
        begin
          core_next.settle_cnt = core_reg.settle_cnt + 4'h1;
        end
      end

      // waiting for the host to pull select low
      QW_IDLE:
      begin
        if (!cs_n_s)
        begin
          core_next.state = QW_FRAME;
        end
      end

      // frame open; its end is the rising edge of select
      QW_FRAME:
      begin
        if (cs_n_s)
        begin
          core_next.settle_cnt = '0;
          core_next.state = QW_SETTLE;
        end
      end

      // the last edge count may still be on its way through the synchroniser
      QW_SETTLE:
      begin
        if (core_reg.settle_cnt == SETTLE_LAST)
        begin
          core_next.settle_cnt = '0;
          core_next.state = QW_LOAD;
        end
        else
        begin
          core_next.settle_cnt = core_reg.settle_cnt + 4'h1;
        end
      end

      // decode and load, or drop a word of the wrong length
      QW_LOAD:
      begin
        core_next.last_len = frame_len;
        core_next.base_cnt = cnt_now;
        core_next.state = QW_IDLE;
        if (frame_ok)
        begin
          // the code itself lands through the channel logic above
          core_next.last_addr = word_in.addr;
          core_next.load_pulse = 1'b1;
          core_next.frame_err = 1'b0;
        end
        else
        begin
          // a short or long word would land bits in the wrong field
          core_next.frame_err = 1'b1;
        end
      end

      default:
      begin
        core_next.settle_cnt = '0;
        core_next.state = QW_INIT;
      end
    endcase

    // synchronous reset to midscale and a quiet sequencer
    if (!reset_n)
    begin
      core_next.state = QW_INIT;
      core_next.settle_cnt = '0;
      core_next.base_cnt = '0;
      for (int ch = 0; ch < NUM_CH; ch++)
      begin
        core_next.wiper[ch] = MIDSCALE_CODE;
      end
      core_next.term_open = '0;
      core_next.load_pulse = 1'b0;
      core_next.frame_err = 1'b0;
      core_next.last_addr = '0;
      core_next.last_len = '0;
    end
  end

  always_ff @(posedge mclk)
  begin
    core_reg <= core_next;
  end

  // register outputs, one wiper code per channel
  assign wiper_ch1 = core_reg.wiper[WIPER_CODE_CH1_OFFSET];
  assign wiper_ch2 = core_reg.wiper[WIPER_CODE_CH2_OFFSET];
  assign wiper_ch3 = core_reg.wiper[WIPER_CODE_CH3_OFFSET];
  assign wiper_ch4 = core_reg.wiper[WIPER_CODE_CH4_OFFSET];

  // status outputs
  assign term_a_open = core_reg.term_open;
  assign load_done = core_reg.load_pulse;
  assign frame_error = core_reg.frame_err;
  assign last_addr = core_reg.last_addr;
  assign last_frame_len = core_reg.last_len;

endmodule
`default_nettype wire

// ### verification/qwsl_loader_chk.sv
// assertions on the ports of the quad wiper serial loader
`timescale 1ns/1ps
`default_nettype none
module qwsl_loader_chk
  import qwsl_pkg::*;
#(
  parameter int FRAME_BITS = 10
) (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic serial_in,
  input wire logic midscale_preset_n,
  input wire logic terminal_open_n,
  input wire logic serial_out_od_o,
  input wire logic serial_out_od_oe,
  input wire logic [qwsl_pkg::DATA_BITS-1:0] wiper_ch1,
  input wire logic [qwsl_pkg::DATA_BITS-1:0] wiper_ch2,
  input wire logic [qwsl_pkg::DATA_BITS-1:0] wiper_ch3,
  input wire logic [qwsl_pkg::DATA_BITS-1:0] wiper_ch4,
  input wire logic [qwsl_pkg::NUM_CH-1:0] term_a_open,
  input wire logic load_done,
  input wire logic frame_error,
  input wire logic [qwsl_pkg::ADDR_BITS-1:0] last_addr,
  input wire logic [qwsl_pkg::CNT_BITS-1:0] last_frame_len
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);
  logic [3:0] others;
  logic [31:0] all_w;
  // channels a load must leave alone
  assign others = ~(4'h1 << last_addr);
  assign all_w = {wiper_ch4, wiper_ch3, wiper_ch2, wiper_ch1};
  preset_mid_a:
    assert property ((!midscale_preset_n) [*4] |-> all_w == {4{8'h80}}) else $error("preset lost");
  shut_all_a:
    assert property ((!terminal_open_n) [*4] |-> term_a_open == 4'hF) else $error("shutdown lost");
  open_idle_a:
    assert property (terminal_open_n [*4] |-> term_a_open == 4'h0) else $error("terminal stuck open");
  od_pull_a:
    assert property (serial_out_od_o == 1'b0 && (cs_n -> !serial_out_od_oe)) else $error("output drives");
  load_cs_a:
    assert property (load_done |-> cs_n && $past(cs_n, 5)) else $error("load without select rise");
  load_route_a:
    assert property (load_done |-> ({$changed(wiper_ch4), $changed(wiper_ch3), $changed(wiper_ch2),
      $changed(wiper_ch1)} & others) == 4'h0) else $error("wrong channel changed");
  code_hold_a:
    assert property (!load_done && midscale_preset_n && $past(midscale_preset_n) && $past(midscale_preset_n, 3)
      |-> $stable(all_w)) else $error("code changed without load");
  load_len_a:
    assert property (load_done |-> last_frame_len == 5'(FRAME_BITS) && !frame_error ##1 !load_done)
      else $error("bad load pulse");
  cover property (load_done && last_addr == 2'h3);
  cover property ($rose(frame_error));
  cover property (term_a_open == 4'hF);
endmodule
bind qwsl_loader qwsl_loader_chk #(.FRAME_BITS(FRAME_BITS)) chk_inst (.mclk(mclk), .reset_n(reset_n),
  .sclk(sclk), .cs_n(cs_n), .serial_in(serial_in), .midscale_preset_n(midscale_preset_n),
  .terminal_open_n(terminal_open_n), .serial_out_od_o(serial_out_od_o), .serial_out_od_oe(serial_out_od_oe),
  .wiper_ch1(wiper_ch1), .wiper_ch2(wiper_ch2), .wiper_ch3(wiper_ch3), .wiper_ch4(wiper_ch4),
  .term_a_open(term_a_open), .load_done(load_done), .frame_error(frame_error), .last_addr(last_addr),
  .last_frame_len(last_frame_len));
`default_nettype wire

// ### verification/qwsl_host.sv
// host serial controller model driving select, clock and data
`timescale 1ns/1ps
`default_nettype none
module qwsl_host (
  input wire logic mclk,
  input wire logic serial_out_od_oe,
  output var logic sclk,
  output var logic cs_n,
  output var logic serial_in
);
  logic first_od;
  // open drain with pull-up: high unless the device pulls
  wire logic od_line = serial_out_od_oe ? 1'b0 : 1'b1;
  initial
  begin
    sclk = 1'b0;
    cs_n = 1'b1;
    serial_in = 1'b0;
    first_od = 1'b1;
  end
  // one frame msb first, n edges, hp is the half period; clock still outside frames
  task automatic send(input logic [9:0] w, input int n, input int hp);
    @(posedge mclk);
    #3;
    cs_n = 1'b0;
    #20;
    first_od = od_line;
    for (int i = 0; i < n; i++)
    begin
      serial_in = w[9-i];
      #(hp / 2);
      sclk = 1'b1;
      #hp;
      sclk = 1'b0;
      #(hp / 2);
    end
    cs_n = 1'b1;
    serial_in = ~serial_in; // released line: show the opposite level
  endtask
  // clock edges with select high, data toggling
  task automatic stray(input int n);
    for (int i = 0; i < n; i++)
    begin
      #40;
      sclk = 1'b1;
      serial_in = ~serial_in;
      #40;
      sclk = 1'b0;
    end
  endtask
endmodule
`default_nettype wire

// ### verification/tb.sv
// self-checking bench for the quad wiper serial loader
`timescale 1ns/1ps
`default_nettype none
module tb;
  import qwsl_pkg::*;
  logic mclk = 1'b0;
  logic reset_n = 1'b1;
  logic midscale_preset_n = 1'b1;
  logic terminal_open_n = 1'b1;
  wire logic sclk, cs_n, serial_in, oe, load_done, frame_error;
  wire logic [7:0] w1, w2, w3, w4;
  wire logic [3:0] term;
  wire logic [1:0] last_addr;
  wire logic [4:0] last_len;
  logic [7:0] exp_code [4];
  logic [9:0] prev_w;
  bit prev_ok = 0;
  int err_count = 0;
  int n_compared = 0;
  int cyc = 0;
  always #5 mclk = ~mclk;
  qwsl_loader qwsl_loader_inst (.mclk(mclk), .reset_n(reset_n), .sclk(sclk), .cs_n(cs_n),
    .serial_in(serial_in), .midscale_preset_n(midscale_preset_n), .terminal_open_n(terminal_open_n),
    .serial_out_od_o(), .serial_out_od_oe(oe), .wiper_ch1(w1), .wiper_ch2(w2), .wiper_ch3(w3),
    .wiper_ch4(w4), .term_a_open(term), .load_done(load_done), .frame_error(frame_error),
    .last_addr(last_addr), .last_frame_len(last_len));
  qwsl_host qwsl_host_inst (.mclk(mclk), .serial_out_od_oe(oe), .sclk(sclk), .cs_n(cs_n),
    .serial_in(serial_in));
  task automatic close_out();
    $display("compared %0d, errors %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic chk_code(input logic [7:0] g, input logic [7:0] e);
    n_compared++;
    if (g !== e)
    begin
      $display("[ERR] %0t code %h not %h", $time, g, e);
      err_count++;
    end
  endtask
  task automatic chk_stat(input logic [4:0] g, input logic [4:0] e);
    n_compared++;
    if (g !== e)
    begin
      $display("[ERR] %0t status %h not %h", $time, g, e);
      err_count++;
    end
  endtask
  task automatic check_all();
    #1; // read after the edge has settled
    chk_code(w1, exp_code[0]);
    chk_code(w2, exp_code[1]);
    chk_code(w3, exp_code[2]);
    chk_code(w4, exp_code[3]);
  endtask
  function automatic logic [9:0] word_of(input logic [1:0] a, input logic [7:0] d);
    return {a, d};
  endfunction
  // full frame, then wait for the load pulse under a bound
  task automatic frame(input logic [1:0] a, input logic [7:0] d, input int hp);
    int k;
    qwsl_host_inst.send(word_of(a, d), 10, hp);
    if (prev_ok)
      chk_stat({4'h0, qwsl_host_inst.first_od}, {4'h0, prev_w[9]});
    prev_w = word_of(a, d);
    prev_ok = 1;
    for (k = 0; k < 20 && load_done !== 1'b1; k++)
    begin
      @(posedge mclk);
      #1;
    end
    exp_code[a] = d;
    chk_stat({4'h0, load_done}, 5'h01);
    chk_stat(last_len, 5'h0A);
    chk_stat({2'h0, frame_error, last_addr}, {3'h0, a});
    repeat (3) @(posedge mclk);
    check_all();
  endtask
  always @(posedge mclk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      err_count++;
      $display("[ERR] %0t timeout", $time);
      close_out();
    end
  end
  initial
  begin
    reset_n <= 1'b0;
    void'($urandom(29));
    foreach (exp_code[i]) exp_code[i] = 8'h80;
    repeat (3) @(posedge mclk);
    reset_n <= 1'b1;
    repeat (10) @(posedge mclk);
    check_all();
    // every address code with corner data, then random words
    for (int i = 0; i < 12; i++)
      frame(i < 4 ? i[1:0] : 2'($urandom), i < 4 ? 8'(i * 85) : 8'($urandom), 40);
    qwsl_host_inst.stray(5);
    repeat (12) @(posedge mclk);
    check_all();
    // nine edges only: refused, flagged
    qwsl_host_inst.send(word_of(2'h2, 8'h3C), 9, 40);
    prev_ok = 0;
    repeat (15) @(posedge mclk);
    #1 chk_stat({4'h0, frame_error}, 5'h01);
    check_all();
    frame(2'h2, 8'h3C, 40);
    @(posedge mclk) midscale_preset_n <= 1'b0;
    repeat (5) @(posedge mclk);
    foreach (exp_code[i]) exp_code[i] = 8'h80;
    #1 check_all();
    @(posedge mclk) midscale_preset_n <= 1'b1;
    repeat (4) @(posedge mclk);
    frame(2'h1, 8'h7E, 40);
    @(posedge mclk) terminal_open_n <= 1'b0;
    repeat (5) @(posedge mclk);
    #1 chk_stat({1'b0, term}, 5'h0F);
    @(posedge mclk) terminal_open_n <= 1'b1;
    repeat (5) @(posedge mclk);
    #1 chk_stat({1'b0, term}, 5'h00);
    // reset in mid-run returns every code to midscale
    @(posedge mclk) reset_n <= 1'b0;
    repeat (3) @(posedge mclk);
    reset_n <= 1'b1;
    repeat (10) @(posedge mclk);
    foreach (exp_code[i]) exp_code[i] = 8'h80;
    check_all();
    // the first word after the second reset must find a fresh edge count
    prev_ok = 0;
    frame(2'h3, 8'h5A, 40);
    close_out();
  end
endmodule
`default_nettype wire
